// File: core/ufcm_pkg.sv
// Behaviour
// - control register zeroed by power-up or watchdog
// - control bit 0 gives data-stage direction
// - bits 3..1 select test or speed mode
// - forced full speed needs memory option bit
// - reset link routes usb reset to processor
// - bit 5 enables remote wakeup
// - low-power bit stops core clock in suspend
// - self-powered firmware keeps low-power bit clear
// - connect bit drives pull-up at once
// - firmware checks bus power before connecting
// - attach state follows only firmware writes, power-up and watchdog
// - firmware sets reset link in the same write as connect
// - usb reset sets flag, masked interrupt 0x38
// - se0 nak mode is normal operation
// - j and k modes driven by hardware
// - test packet mode repeats loaded packet
// - mask register zeroed by power-up or watchdog
// - mask bits 5..0 enable six events
// - firmware keeps mask bits 7..6 zero
// - status flags cleared by writing one
// - usb reset with link clears other flags
package ufcm_pkg;
	localparam logic [15:0] UFCM_CTL_ADDR  = 16'hf006;
	localparam logic [15:0] UFCM_MSK_ADDR  = 16'hf007;
	localparam logic [15:0] UFCM_STA_ADDR  = 16'hf008;
	localparam logic [7:0]  UFCM_REG_RESET = 8'h00;
	localparam int          UFCM_DIR_BIT   = 0;
	localparam int          UFCM_TSEL_LSB  = 1;
	localparam int          UFCM_LINK_BIT  = 4;
	localparam int          UFCM_RWU_BIT   = 5;
	localparam int          UFCM_LOW_POWER_ENABLE_BIT  = 6;
	localparam int          UFCM_CONN_BIT  = 7;
	localparam int          UFCM_EVT_N     = 6;
	localparam int          UFCM_EVT_WAKE  = 2;
	localparam int          UFCM_EVT_RST   = 5;
	localparam logic [7:0]  UFCM_MSK_RSV   = 8'hc0;
	localparam logic [2:0]  UFCM_TS_NORMAL = 3'h0;
	localparam logic [2:0]  UFCM_TS_SE0NAK = 3'h1;
	localparam logic [2:0]  UFCM_TS_J      = 3'h2;
	localparam logic [2:0]  UFCM_TS_K      = 3'h3;
	localparam logic [2:0]  UFCM_TS_PACKET = 3'h4;
	localparam logic [2:0]  UFCM_TS_FORCFS = 3'h5;
	localparam logic [7:0]  UFCM_VEC_NONE  = 8'h00;
	// setup_overwrite, setup, wakeup clock, resume, suspend, function reset
	localparam logic [7:0]  UFCM_VEC [UFCM_EVT_N] =
		'{8'h30, 8'h32, 8'h4a, 8'h34, 8'h36, 8'h38};
	// controller register map on the software bus
	localparam logic [3:0]  UFCM_CMD_OFS   = 4'h0;
	localparam logic [3:0]  UFCM_STAT_OFS  = 4'h4;
	localparam logic [3:0]  UFCM_CFG_OFS   = 4'h8;
	localparam int          UFCM_CMD_DLSB  = 16;
	localparam int          UFCM_CMD_WRBIT = 24;
	localparam int          UFCM_ST_BUSY   = 0;
	localparam int          UFCM_ST_REFUSE = 1;
	localparam int          UFCM_ST_VBUS   = 2;
	localparam int          UFCM_ST_DLSB   = 8;
	localparam int          UFCM_CF_SELF   = 0;
	localparam int          UFCM_CF_FSOPT  = 1;
	localparam logic [1:0]  UFCM_HT_NONSEQ = 2'h2;
	localparam logic        UFCM_HR_OKAY   = 1'h0;
endpackage : ufcm_pkg

// File: core/ufcm_external_data_space_if.sv
`timescale 1ns/10ps
interface ufcm_external_data_space_if (
	input wire logic hclk,
	input wire logic hresetn
);
	logic        req;
	logic        we;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        ack;
	logic [7:0]  rdata;
	modport dev (
		input  req,
		input  we,
		input  addr,
		input  wdata,
		output ack,
		output rdata
	);
	modport ctl (
		output req,
		output we,
		output addr,
		output wdata,
		input  ack,
		input  rdata
	);
endinterface : ufcm_external_data_space_if

// File: core/ufcm_device.sv
`timescale 1ns/10ps
module ufcm_device
	import ufcm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	ufcm_external_data_space_if.dev        xbus,
	input  wire logic        watchdog_reset,
	input  wire logic        usb_reset_det,
	input  wire logic [4:0]  event_det,
	input  wire logic        suspended,
	output logic             xfer_dir_in,
	output logic [2:0]       test_select,
	output logic             force_full_speed,
	output logic             drive_j,
	output logic             drive_k,
	output logic             test_packet_repeat,
	output logic             remote_wakeup_enable,
	output logic             core_clock_stop,
	output logic             upstream_pullup,
	output logic             processor_reset,
	output logic             irq,
	output logic [7:0]       irq_vector
);
	typedef struct packed {
		logic [7:0]            ctl;
		logic [7:0]            msk;
		logic [UFCM_EVT_N-1:0] sta;
		logic                  ack;
		logic [7:0]            rdata;
		logic                  dir;
		logic [2:0]            tsel;
		logic                  ffs;
		logic                  j;
		logic                  k;
		logic                  pkt;
		logic                  rwu;
		logic                  ccs;
		logic                  pull;
		logic                  prst;
		logic                  irq;
		logic [7:0]            vec;
	} ufcm_dev_state_type;

	localparam ufcm_dev_state_type UFCM_DEV_RST = '0;

	ufcm_dev_state_type s_q;
	ufcm_dev_state_type s_d;

	// wakeup clock sits in the higher group, so it is served first;
	// inside the lower group the lowest pending index wins
	function automatic logic [7:0] ufcm_pick_vec(
		input logic [UFCM_EVT_N-1:0] pend
	);
		logic [7:0] v;
		v = UFCM_VEC_NONE;
		for (int i = UFCM_EVT_N - 1; i >= 0; i--) begin
			if (pend[i]) begin
				v = UFCM_VEC[i];
			end
		end
		if (pend[UFCM_EVT_WAKE]) begin
			v = UFCM_VEC[UFCM_EVT_WAKE];
		end
		return v;
	endfunction : ufcm_pick_vec

	// one decoder for every register write strobe
	function automatic logic ufcm_wr_hit(
		input logic        req,
		input logic        we,
		input logic [15:0] a,
		input logic [15:0] target
	);
		return req && we && (a == target);
	endfunction : ufcm_wr_hit

	// unmapped addresses read as zero so probing is harmless
	function automatic logic [7:0] ufcm_read_mux(
		input logic [15:0]           a,
		input logic [7:0]            ctl,
		input logic [7:0]            msk,
		input logic [UFCM_EVT_N-1:0] sta
	);
		logic [7:0] v;
		unique case (a)
			UFCM_CTL_ADDR: v = ctl;
			UFCM_MSK_ADDR: v = msk;
			UFCM_STA_ADDR: v = {2'h0, sta};
			default:       v = UFCM_REG_RESET;
		endcase
		return v;
	endfunction : ufcm_read_mux

	// usb reset must be the top flag, the event pins fill the rest
	if (UFCM_EVT_RST != UFCM_EVT_N - 1) begin : g_rst_top
		$error("usb reset must be the top event flag");
	end
	// one pin per event below the usb reset flag
	if ($bits(event_det) != UFCM_EVT_N - 1) begin : g_evt_pins
		$error("event pin count does not match the flag count");
	end

	logic                  wr_ctl;
	logic                  wr_msk;
	logic                  wr_sta;
	logic                  rd;
	logic                  link_rst;
	logic [UFCM_EVT_N-1:0] ev_set;
	logic [UFCM_EVT_N-1:0] ev_clr;
	logic [UFCM_EVT_N-1:0] pend;
	logic [UFCM_EVT_N-1:0] keep_rst;

	always_comb begin
		s_d = s_q;
		wr_ctl = ufcm_wr_hit(xbus.req, xbus.we, xbus.addr,
			UFCM_CTL_ADDR);
		wr_msk = ufcm_wr_hit(xbus.req, xbus.we, xbus.addr,
			UFCM_MSK_ADDR);
		wr_sta = ufcm_wr_hit(xbus.req, xbus.we, xbus.addr,
			UFCM_STA_ADDR);
		rd = xbus.req && !xbus.we;
		link_rst = usb_reset_det && s_q.ctl[UFCM_LINK_BIT];
		keep_rst = '0;
		keep_rst[UFCM_EVT_RST] = 1'b1;
		ev_set = {usb_reset_det, event_det};
		ev_clr = '0;
		if (wr_sta) begin
			ev_clr = xbus.wdata[UFCM_EVT_N-1:0];
		end
		if (link_rst) begin
			ev_clr = ev_clr | ~keep_rst;
		end

		// one-cycle answer to every access, unmapped reads give zero
		s_d.ack = xbus.req;
		s_d.rdata = UFCM_REG_RESET;
		if (rd) begin
			s_d.rdata = ufcm_read_mux(xbus.addr, s_q.ctl, s_q.msk,
				s_q.sta);
		end

		// usb reset never touches these two registers
		if (wr_ctl) begin
			s_d.ctl = xbus.wdata;
		end
		if (wr_msk) begin
			s_d.msk = xbus.wdata;
		end
		// a flag raised in the clearing cycle survives
		for (int b = 0; b < UFCM_EVT_N; b++) begin
			if (ev_set[b]) begin
				s_d.sta[b] = 1'b1;
			end else if (ev_clr[b]) begin
				s_d.sta[b] = 1'b0;
			end
		end

		if (watchdog_reset) begin
			s_d.ctl = UFCM_REG_RESET;
			s_d.msk = UFCM_REG_RESET;
			s_d.sta = '0;
		end

		s_d.dir = s_d.ctl[UFCM_DIR_BIT];
		s_d.tsel = s_d.ctl[UFCM_TSEL_LSB +: 3];
		s_d.ffs = 1'b0;
		s_d.j = 1'b0;
		s_d.k = 1'b0;
		s_d.pkt = 1'b0;
		unique case (s_d.tsel)
			// se0 nak and normal both leave the line to normal logic
			UFCM_TS_NORMAL, UFCM_TS_SE0NAK: ;
			UFCM_TS_J:      s_d.j = 1'b1;
			UFCM_TS_K:      s_d.k = 1'b1;
			UFCM_TS_PACKET: s_d.pkt = 1'b1;
			UFCM_TS_FORCFS: s_d.ffs = 1'b1;
			// unused codes run as normal operation
			default: ;
		endcase
		s_d.rwu = s_d.ctl[UFCM_RWU_BIT];
		s_d.ccs = s_d.ctl[UFCM_LOW_POWER_ENABLE_BIT] && suspended;
		// no bus power check here, firmware owns that
		s_d.pull = s_d.ctl[UFCM_CONN_BIT];
		s_d.prst = link_rst && !watchdog_reset;

		pend = s_d.sta & s_d.msk[UFCM_EVT_N-1:0];
		s_d.irq = |pend;
		s_d.vec = ufcm_pick_vec(pend);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= UFCM_DEV_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign xbus.ack = s_q.ack;
	assign xbus.rdata = s_q.rdata;
	assign xfer_dir_in = s_q.dir;
	assign test_select = s_q.tsel;
	assign force_full_speed = s_q.ffs;
	assign drive_j = s_q.j;
	assign drive_k = s_q.k;
	assign test_packet_repeat = s_q.pkt;
	assign remote_wakeup_enable = s_q.rwu;
	assign core_clock_stop = s_q.ccs;
	assign upstream_pullup = s_q.pull;
	assign processor_reset = s_q.prst;
	assign irq = s_q.irq;
	assign irq_vector = s_q.vec;
endmodule : ufcm_device

// File: core/ufcm_controller.sv
`timescale 1ns/10ps
module ufcm_controller
	import ufcm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        vbus_present,
	ufcm_external_data_space_if.ctl        xbus
);
	typedef struct packed {
		logic [2:0]  vsync;
		logic        vbus;
		logic        dph;
		logic        dwr;
		logic [3:0]  dofs;
		logic        hrdy;
		logic [31:0] hrd;
		logic        hrsp;
		logic        self_pw;
		logic        fs_opt;
		logic        busy;
		logic        refused;
		logic [7:0]  last;
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ufcm_ctl_state_type;

	localparam ufcm_ctl_state_type UFCM_CTL_RST = '{hrdy: 1'b1,
		hrsp: UFCM_HR_OKAY, default: '0};

	ufcm_ctl_state_type s_q;
	ufcm_ctl_state_type s_d;
	logic [7:0]         d;
	logic               cmd_wr;
	logic               take;

	always_comb begin
		s_d = s_q;
		d = hwdata[UFCM_CMD_DLSB +: 8];
		s_d.req = 1'b0;
		// three stages; a change counts once the last two agree
		s_d.vsync = {s_q.vsync[1:0], vbus_present};
		if (s_q.vsync[1] == s_q.vsync[2]) begin
			s_d.vbus = s_q.vsync[2];
		end
		if (xbus.ack) begin
			s_d.busy = 1'b0;
			s_d.last = xbus.rdata;
		end

		cmd_wr = s_q.dph && s_q.dwr && (s_q.dofs == UFCM_CMD_OFS);
		take = cmd_wr && !s_q.busy;
		if (hwdata[UFCM_CMD_WRBIT] && take) begin
			if (hwdata[15:0] == UFCM_CTL_ADDR) begin
				if (s_q.self_pw) begin
					d[UFCM_LOW_POWER_ENABLE_BIT] = 1'b0;
				end
				if (!s_q.vbus) begin
					d[UFCM_CONN_BIT] = 1'b0;
				end
				if (d[UFCM_TSEL_LSB +: 3] == UFCM_TS_FORCFS &&
						!s_q.fs_opt) begin
					d[UFCM_TSEL_LSB +: 3] = UFCM_TS_NORMAL;
				end
				if (d[UFCM_CONN_BIT]) begin
					d[UFCM_LINK_BIT] = 1'b1;
				end
			end
			if (hwdata[15:0] == UFCM_MSK_ADDR) begin
				d = d & ~UFCM_MSK_RSV;
			end
		end
		// direction and packet mode pass as written, test select too except forced full speed without fs_opt
		if (take) begin
			s_d.req = 1'b1;
			s_d.busy = 1'b1;
			s_d.we = hwdata[UFCM_CMD_WRBIT];
			s_d.addr = hwdata[15:0];
			s_d.wdata = d;
		end
		if (s_q.dph && s_q.dwr && s_q.dofs == UFCM_CFG_OFS) begin
			s_d.self_pw = hwdata[UFCM_CF_SELF];
			s_d.fs_opt = hwdata[UFCM_CF_FSOPT];
		end
		if (s_q.dph && s_q.dwr && s_q.dofs == UFCM_STAT_OFS &&
				hwdata[UFCM_ST_REFUSE]) begin
			s_d.refused = 1'b0;
		end
		// refusal set after the clear so it wins
		if ((cmd_wr && s_q.busy) ||
				(take && d != hwdata[UFCM_CMD_DLSB +: 8])) begin
			s_d.refused = 1'b1;
		end

		// reads take one wait state so hrdata comes from a flop
		if (s_q.dph && !s_q.dwr) begin
			s_d.hrd = '0;
			unique case (s_q.dofs)
				UFCM_STAT_OFS: begin
					s_d.hrd[UFCM_ST_BUSY] = s_q.busy;
					s_d.hrd[UFCM_ST_REFUSE] = s_q.refused;
					s_d.hrd[UFCM_ST_VBUS] = s_q.vbus;
					s_d.hrd[UFCM_ST_DLSB +: 8] = s_q.last;
				end
				UFCM_CFG_OFS: begin
					s_d.hrd[UFCM_CF_SELF] = s_q.self_pw;
					s_d.hrd[UFCM_CF_FSOPT] = s_q.fs_opt;
				end
				default: s_d.hrd = '0;
			endcase
			s_d.hrdy = 1'b1;
		end
		s_d.dph = 1'b0;
		if (hsel && hready && htrans == UFCM_HT_NONSEQ) begin
			s_d.dph = 1'b1;
			s_d.dwr = hwrite;
			s_d.dofs = haddr[3:0];
			s_d.hrdy = hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= UFCM_CTL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign hreadyout = s_q.hrdy;
	assign hrdata = s_q.hrd;
	assign hresp = s_q.hrsp;
	assign xbus.req = s_q.req;
	assign xbus.we = s_q.we;
	assign xbus.addr = s_q.addr;
	assign xbus.wdata = s_q.wdata;
endmodule : ufcm_controller

// File: sim/ufcm_monitor.sv
`timescale 1ns/10ps
module ufcm_monitor
	import ufcm_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        req,
	input wire logic        we,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        ack,
	input wire logic [7:0]  rdata
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ack_after_req_a: assert property (req |=> ack)
		else $error("ack missing after request");
	ack_has_req_a: assert property (ack |-> $past(req))
		else $error("ack without request");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	req_single_a: assert property (req |=> !req ##1 !req)
		else $error("requests too close");
	wr_rdata_zero_a: assert property (ack && $past(we) |-> rdata == 8'h00)
		else $error("read data on a write");
	msk_rsv_zero_a: assert property (ack && !$past(we) &&
		$past(addr) == UFCM_MSK_ADDR |-> rdata[7:6] == 2'b00)
		else $error("mask reserved bits set");
	sta_rsv_zero_a: assert property (ack && !$past(we) &&
		$past(addr) == UFCM_STA_ADDR |-> rdata[7:6] == 2'b00)
		else $error("status reserved bits set");
	unmapped_zero_a: assert property (ack && !$past(we) &&
		($past(addr) < UFCM_CTL_ADDR || $past(addr) > UFCM_STA_ADDR)
		|-> rdata == 8'h00)
		else $error("unmapped read not zero");
	msk_wr_rsv_a: assert property (req && we &&
		addr == UFCM_MSK_ADDR |-> wdata[7:6] == 2'b00)
		else $error("mask write sets reserved bits");
	connect_link_a: assert property (req && we &&
		addr == UFCM_CTL_ADDR && wdata[UFCM_CONN_BIT]
		|-> wdata[UFCM_LINK_BIT])
		else $error("connect written without reset link");
endmodule : ufcm_monitor

// File: sim/tb.sv
`timescale 1ns/10ps
module tb;
	import ufcm_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, w;
	logic [1:0]  htrans = 2'h0;
	logic        hready, hresp, vbus_present = 1'b1;
	logic        watchdog_reset = 1'b0, usb_reset_det = 1'b0;
	logic [4:0]  event_det = 5'h0;
	logic        suspended = 1'b0, xfer_dir_in, force_full_speed, drive_j;
	logic        drive_k, test_packet_repeat, remote_wakeup_enable;
	logic        core_clock_stop, upstream_pullup, processor_reset, irq;
	logic [7:0]  irq_vector, r;
	logic [2:0]  test_select, ts, hsize = 3'h0;
	int          n_mismatch = 0, comparisons = 0, i;
	always #2.5 hclk = ~hclk;
	ufcm_external_data_space_if u_ufcm_external_data_space_if (.hclk, .hresetn);
	ufcm_controller u_ufcm_controller (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout(hready), .hrdata, .hresp, .vbus_present,
		.xbus(u_ufcm_external_data_space_if.ctl));
	ufcm_device u_ufcm_device (.hclk, .hresetn, .xbus(u_ufcm_external_data_space_if.dev),
		.watchdog_reset, .usb_reset_det, .event_det, .suspended,
		.xfer_dir_in, .test_select, .force_full_speed, .drive_j, .drive_k,
		.test_packet_repeat, .remote_wakeup_enable, .core_clock_stop,
		.upstream_pullup, .processor_reset, .irq, .irq_vector);
	ufcm_monitor u_ufcm_monitor (.hclk, .hresetn,
		.req(u_ufcm_external_data_space_if.req), .we(u_ufcm_external_data_space_if.we),
		.addr(u_ufcm_external_data_space_if.addr), .wdata(u_ufcm_external_data_space_if.wdata),
		.ack(u_ufcm_external_data_space_if.ack), .rdata(u_ufcm_external_data_space_if.rdata));
	task summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'h2;
		htrans <= UFCM_HT_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : ahb
	// device byte access through the command register, polled until idle
	task dev(input logic wr, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [31:0] s;
		ahb(1'b1, 32'(UFCM_CMD_OFS), {7'h0, wr, d, a}, s);
		do ahb(1'b0, 32'(UFCM_STAT_OFS), 32'h0, s); while (s[0] !== 1'b0);
		q = s[15:8];
	endtask : dev
	// one-cycle pulse of {watchdog, usb reset, events}, checked after edge
	task strobe(input logic [6:0] v);
		@(posedge hclk);
		{watchdog_reset, usb_reset_det, event_det} <= v;
		@(posedge hclk);
		{watchdog_reset, usb_reset_det, event_det} <= 7'h0;
		#1;
	endtask : strobe
	initial begin
		#50000;
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		dev(0, UFCM_CTL_ADDR, 0, r); chk(r, 0);
		dev(0, UFCM_MSK_ADDR, 0, r); chk(r, 0);
		ahb(0, 32'hc, 0, w); chk(w, 0);
		chk(hresp, UFCM_HR_OKAY);
		dev(0, UFCM_STA_ADDR + 16'h1, 0, r); chk(r, 0);
		$display("test reset done");
		ahb(1, 32'(UFCM_CFG_OFS), 32'h2, w);
		for (i = 0; i < 6; i++) begin
			ts = i[2:0];
			dev(1, UFCM_CTL_ADDR, {4'ha, ts, 1'b1}, r);
			dev(0, UFCM_CTL_ADDR, 0, r); chk(r, {4'hb, ts, 1'b1});
			chk({xfer_dir_in, upstream_pullup, remote_wakeup_enable, test_select,
				drive_j, drive_k, test_packet_repeat, force_full_speed},
				{3'h7, ts, ts == 3'h2, ts == 3'h3, ts == 3'h4, ts == 3'h5});
		end
		$display("test modes done");
		dev(1, UFCM_CTL_ADDR, 8'h40, r);
		suspended <= 1'b1;
		strobe(7'h0);
		chk({core_clock_stop, upstream_pullup}, 2'b10);
		suspended <= 1'b0;
		ahb(1, 32'(UFCM_CFG_OFS), 32'h3, w);
		dev(1, UFCM_CTL_ADDR, 8'h40, r);
		dev(0, UFCM_CTL_ADDR, 0, r); chk(r, 0);
		ahb(1, 32'(UFCM_CFG_OFS), 32'h0, w);
		ahb(1, 32'(UFCM_STAT_OFS), 32'h2, w);
		dev(1, UFCM_CTL_ADDR, 8'h0a, r);
		dev(0, UFCM_CTL_ADDR, 0, r); chk(r, 0);
		ahb(0, 32'(UFCM_STAT_OFS), 32'h0, w); chk(w, 32'h6);
		ahb(1, 32'(UFCM_CFG_OFS), 32'h2, w);
		vbus_present <= 1'b0;
		repeat (5) strobe(7'h0);
		dev(1, UFCM_CTL_ADDR, 8'h80, r);
		dev(0, UFCM_CTL_ADDR, 0, r); chk(r, 0);
		chk(upstream_pullup, 0);
		ahb(0, 32'(UFCM_STAT_OFS), 32'h0, w); chk(w, 32'h2);
		vbus_present <= 1'b1;
		$display("test power done");
		dev(1, UFCM_MSK_ADDR, 8'hff, r);
		dev(0, UFCM_MSK_ADDR, 0, r); chk(r, 8'h3f);
		for (i = 0; i < 5; i++) begin
			strobe(7'(1 << i));
			chk({irq, irq_vector}, {1'b1, UFCM_VEC[i]});
			dev(1, UFCM_STA_ADDR, 0, r);
			dev(0, UFCM_STA_ADDR, 0, r); chk(r, 1 << i);
			dev(1, UFCM_STA_ADDR, 8'(1 << i), r);
			chk(irq, 0);
		end
		dev(1, UFCM_MSK_ADDR, 8'h20, r);
		strobe(7'h01);
		chk(irq, 0);
		$display("test events done");
		dev(1, UFCM_CTL_ADDR, 8'h10, r);
		strobe(7'h10);
		strobe(7'h20);
		chk({processor_reset, irq, irq_vector}, {2'b11, 8'h38});
		dev(0, UFCM_STA_ADDR, 0, r); chk(r, 8'h20);
		dev(0, UFCM_CTL_ADDR, 0, r); chk(r, 8'h10);
		dev(0, UFCM_MSK_ADDR, 0, r); chk(r, 8'h20);
		dev(1, UFCM_CTL_ADDR, 8'h21, r);
		strobe(7'h20);
		chk(processor_reset, 0);
		$display("test usb reset done");
		strobe(7'h40);
		dev(0, UFCM_CTL_ADDR, 0, r); chk(r, 0);
		dev(0, UFCM_MSK_ADDR, 0, r); chk(r, 0);
		dev(0, UFCM_STA_ADDR, 0, r); chk(r, 0);
		$display("test watchdog done");
		summarize();
	end
endmodule : tb
